// file: design/emx_ctrl.sv
`timescale 1ns/1ps
module emx_ctrl #(
  parameter int DIV_HALF = emx_pkg::DIV_HALF
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [emx_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic memClockOutDivided,
  output logic [emx_pkg::NSPACE-1:0] spaceChipEnable_n,
  output logic [emx_pkg::BE_W-1:0] byteLaneEnable_n,
  output logic [emx_pkg::ADDR_W-1:0] extAddressBus,
  input wire logic [emx_pkg::DATA_W-1:0] extDataBusIn,
  output logic [emx_pkg::DATA_W-1:0] extDataBusOut,
  output logic extDataBusOe_n,
  output logic sharedStrobe_n,
  output logic sharedOutputEnable_n,
  output logic sharedWriteEnable_n,
  input wire logic extReadyIn
);
  import emx_pkg::*;

  typedef struct packed {
    emx_state_t st;
    logic [5:0] cnt;
    logic sawLow;
    logic wr;
    logic [1:0] space;
    logic rdyMeta;
    logic rdySync;
    logic [7:0] divCnt;
    logic clkDiv;
    logic [NSPACE-1:0][31:0] ctl;
    logic [NSPACE-1:0][SEC_W-1:0] sec;
    logic [31:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic busy;
    logic done;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [NSPACE-1:0] ce_n;
    logic [BE_W-1:0] be_n;
    logic [ADDR_W-1:0] ea;
    logic [DATA_W-1:0] dout;
    logic doe_n;
    logic strobe_n;
    logic oe_n;
    logic we_n;
  } emx_regs_t;

  emx_regs_t s_r;
  emx_regs_t s_nxt;

  logic [31:0] curCtl;
  logic [SEC_W-1:0] curSec;
  logic step;
  logic inWindow;
  logic [5:0] ldSetup;
  logic [5:0] ldStrobe;
  logic [5:0] ldHold;
  logic [1:0] latency;
  logic [1:0] apbSpace;
  logic apbIsCtl;
  logic apbIsSec;
  logic apbHit;

  // configuration of the space in flight
  always_comb begin
    curCtl = s_r.ctl[s_r.space];
    curSec = s_r.sec[s_r.space];
  end

  // phase lengths from the active space, zero counts as one
  always_comb begin
    if (s_r.wr) begin
      ldSetup = {2'b00, curCtl[WS_POS +: SETUP_W]};
      ldStrobe = curCtl[WST_POS +: STROBE_W];
      ldHold = {4'h0, curCtl[WH_POS +: HOLD_W]};
      latency = curSec[SWL_POS +: 2];
    end else begin
      ldSetup = {2'b00, curCtl[RS_POS +: SETUP_W]};
      ldStrobe = curCtl[RST_POS +: STROBE_W];
      ldHold = {4'h0, curCtl[RH_POS +: HOLD_W]};
      latency = curSec[SRL_POS +: 2];
    end
    if (ldSetup == 6'h00) begin
      ldSetup = 6'h01;
    end
    if (ldStrobe == 6'h00) begin
      ldStrobe = 6'h01;
    end
  end

  // step marks the edge where the selected memory clock rises
  // full or divided clock
  always_comb begin
    if (curSec[SYNC_CLOCK_SELECT_POS]) begin
      step = (s_r.divCnt == 8'(DIV_HALF - 1)) && !s_r.clkDiv;
    end else begin
      step = 1'b1;
    end
    inWindow = (s_r.cnt <= RDY_WINDOW);
  end

  // decode of space registers on the apb address
  always_comb begin
    apbSpace = 2'd0;
    apbIsCtl = 1'b0;
    apbIsSec = 1'b0;
    case (paddr)
      OFS_CTL0: begin
        apbIsCtl = 1'b1;
      end
      OFS_CTL1: begin
        apbIsCtl = 1'b1;
        apbSpace = 2'd1;
      end
      OFS_CTL2: begin
        apbIsCtl = 1'b1;
        apbSpace = 2'd2;
      end
      OFS_CTL3: begin
        apbIsCtl = 1'b1;
        apbSpace = 2'd3;
      end
      OFS_SEC0: begin
        apbIsSec = 1'b1;
      end
      OFS_SEC1: begin
        apbIsSec = 1'b1;
        apbSpace = 2'd1;
      end
      OFS_SEC2: begin
        apbIsSec = 1'b1;
        apbSpace = 2'd2;
      end
      OFS_SEC3: begin
        apbIsSec = 1'b1;
        apbSpace = 2'd3;
      end
      default: begin
        apbSpace = 2'd0;
      end
    endcase
    apbHit = apbIsCtl || apbIsSec || (paddr == OFS_ADDR) || (paddr == OFS_WDLO)
      || (paddr == OFS_WDHI) || (paddr == OFS_CMD) || (paddr == OFS_RDLO)
      || (paddr == OFS_RDHI) || (paddr == OFS_STAT);
  end

  // next state of the whole block
  always_comb begin
    s_nxt = s_r;
    s_nxt.rdyMeta = extReadyIn;
    s_nxt.rdySync = s_r.rdyMeta;
    // free-running divided clock
    if (s_r.divCnt == 8'(DIV_HALF - 1)) begin
      s_nxt.divCnt = 8'h00;
      s_nxt.clkDiv = !s_r.clkDiv;
    end else begin
      s_nxt.divCnt = s_r.divCnt + 8'h01;
    end

    // access sequencer
    case (s_r.st)
      ST_IDLE: begin
        s_nxt.sawLow = 1'b0;
      end
      ST_ASETUP: begin
        if (s_r.cnt == 6'h00) begin
          // setup length loaded once the new space is latched
          s_nxt.cnt = ldSetup;
        end else if (s_r.cnt <= 6'h01) begin
          s_nxt.st = ST_ASTROBE;
          s_nxt.cnt = ldStrobe;
          s_nxt.strobe_n = s_r.wr;
          s_nxt.we_n = !s_r.wr;
        end else begin
          s_nxt.cnt = s_r.cnt - 6'h01;
        end
      end
      ST_ASTROBE: begin
        if (inWindow && !s_r.rdySync) begin
          s_nxt.cnt = RDY_WINDOW;
          s_nxt.sawLow = 1'b1;
        end else if (s_r.cnt <= 6'h01) begin
          // capture read data at strobe rise
          if (!s_r.wr) begin
            s_nxt.rdata = extDataBusIn;
          end
          s_nxt.strobe_n = 1'b1;
          s_nxt.we_n = 1'b1;
          s_nxt.cnt = ldHold;
          s_nxt.st = ST_AHOLD;
        end else begin
          // two cycles from first high sample
          s_nxt.cnt = s_r.cnt - 6'h01;
        end
      end
      ST_AHOLD: begin
        if (s_r.cnt <= 6'h01) begin
          s_nxt.st = ST_IDLE;
        end else begin
          s_nxt.cnt = s_r.cnt - 6'h01;
        end
      end
      // command issued on selected clock rise
      ST_SCMD: begin
        if (step) begin
          s_nxt.ce_n[s_r.space] = 1'b0;
          s_nxt.be_n = ~s_r.addr[AR_BE_POS +: BE_W];
          s_nxt.ea = s_r.addr[ADDR_W-1:0];
          // strobe, oe and we as sync pins
          s_nxt.strobe_n = 1'b0;
          s_nxt.oe_n = s_r.wr;
          s_nxt.we_n = !s_r.wr;
          // zero write latency drives data now
          if (s_r.wr && latency == 2'd0) begin
            s_nxt.dout = s_r.wdata;
            s_nxt.doe_n = 1'b0;
          end
          s_nxt.cnt = {4'h0, latency};
          s_nxt.st = ST_SLAT;
        end
      end
      ST_SLAT: begin
        if (step) begin
          s_nxt.strobe_n = 1'b1;
          s_nxt.we_n = 1'b1;
          if (!(curSec[CHIP_ENABLE_EXTEND_POS] && !s_r.wr)) begin
            s_nxt.ce_n = '1;
          end
          if (s_r.cnt == 6'h00) begin
            if (!s_r.wr) begin
              s_nxt.rdata = extDataBusIn;
            end
            s_nxt.oe_n = 1'b1;
            s_nxt.ce_n = '1;
            s_nxt.doe_n = 1'b1;
            if (curSec[RENSEL_POS]) begin
              s_nxt.st = ST_IDLE;
            end else begin
              s_nxt.st = ST_SDESEL;
              s_nxt.strobe_n = 1'b0;
            end
          end else begin
            s_nxt.cnt = s_r.cnt - 6'h01;
            if (s_r.wr && s_r.cnt == 6'h01) begin
              s_nxt.dout = s_r.wdata;
              s_nxt.doe_n = 1'b0;
            end
          end
        end
      end
      ST_SDESEL: begin
        if (step) begin
          s_nxt.strobe_n = 1'b1;
          s_nxt.st = ST_IDLE;
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase

    // release the bus when any access ends
    if (s_r.st != ST_IDLE && s_nxt.st == ST_IDLE) begin
      s_nxt.ce_n = '1;
      s_nxt.be_n = '1;
      s_nxt.oe_n = 1'b1;
      s_nxt.doe_n = 1'b1;
      s_nxt.strobe_n = 1'b1;
      s_nxt.we_n = 1'b1;
      s_nxt.busy = 1'b0;
    end

    // apb setup phase: answer ready in the access phase
    s_nxt.pready = 1'b0;
    s_nxt.pslverr = 1'b0;
    if (psel && !penable && !s_r.pready) begin
      s_nxt.pready = 1'b1;
      s_nxt.pslverr = !apbHit;
      s_nxt.prdata = 32'h0000_0000;
      if (apbIsCtl) begin
        s_nxt.prdata = s_r.ctl[apbSpace];
      end else if (apbIsSec) begin
        s_nxt.prdata = {25'h0, s_r.sec[apbSpace]};
      end else begin
        case (paddr)
          OFS_ADDR: s_nxt.prdata = s_r.addr;
          OFS_WDLO: s_nxt.prdata = s_r.wdata[31:0];
          OFS_WDHI: s_nxt.prdata = s_r.wdata[63:32];
          OFS_RDLO: s_nxt.prdata = s_r.rdata[31:0];
          OFS_RDHI: s_nxt.prdata = s_r.rdata[63:32];
          OFS_STAT: s_nxt.prdata = {30'h0, s_r.done, s_r.busy};
          default: s_nxt.prdata = 32'h0000_0000;
        endcase
      end
    end

    // apb write takes effect at the edge that ends the access phase
    if (psel && penable && pwrite && s_r.pready && apbHit) begin
      if (apbIsCtl) begin
        s_nxt.ctl[apbSpace] = pwdata;
      end else if (apbIsSec) begin
        s_nxt.sec[apbSpace] = pwdata[SEC_W-1:0];
      end else begin
        case (paddr)
          OFS_ADDR: s_nxt.addr = pwdata;
          OFS_WDLO: s_nxt.wdata[31:0] = pwdata;
          OFS_WDHI: s_nxt.wdata[63:32] = pwdata;
          OFS_STAT: begin
            if (pwdata[ST_DONE_POS]) begin
              s_nxt.done = 1'b0;
            end
          end
          OFS_CMD: begin
            if (pwdata[CMD_GO_POS] && !s_r.busy) begin
              s_nxt.busy = 1'b1;
              s_nxt.wr = pwdata[CMD_WR_POS];
              s_nxt.space = s_r.addr[AR_SPACE_POS +: 2];
              s_nxt.sawLow = 1'b0;
              if (s_r.ctl[s_r.addr[AR_SPACE_POS +: 2]][SYNC_POS]) begin
                s_nxt.st = ST_SCMD;
              end else begin
                s_nxt.st = ST_ASETUP;
                s_nxt.cnt = 6'h00;
                s_nxt.ce_n = '1;
                s_nxt.ce_n[s_r.addr[AR_SPACE_POS +: 2]] = 1'b0;
                s_nxt.be_n = ~s_r.addr[AR_BE_POS +: BE_W];
                s_nxt.ea = s_r.addr[ADDR_W-1:0];
                s_nxt.oe_n = pwdata[CMD_WR_POS];
                s_nxt.dout = s_r.wdata;
                s_nxt.doe_n = !pwdata[CMD_WR_POS];
              end
            end
          end
          default: begin
            s_nxt.done = s_r.done;
          end
        endcase
      end
    end

    // finishing access sets done; set wins over clear
    if (s_r.st != ST_IDLE && s_nxt.st == ST_IDLE) begin
      s_nxt.done = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
      for (int i = 0; i < NSPACE; i++) begin
        s_r.ctl[i] <= CTL_RST;
        s_r.sec[i] <= SEC_RST;
      end
      s_r.ce_n <= '1;
      s_r.be_n <= '1;
      s_r.doe_n <= 1'b1;
      s_r.strobe_n <= 1'b1;
      s_r.oe_n <= 1'b1;
      s_r.we_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state flops
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign memClockOutDivided = s_r.clkDiv;
  assign spaceChipEnable_n = s_r.ce_n;
  assign byteLaneEnable_n = s_r.be_n;
  assign extAddressBus = s_r.ea;
  assign extDataBusOut = s_r.dout;
  assign extDataBusOe_n = s_r.doe_n;
  assign sharedStrobe_n = s_r.strobe_n;
  assign sharedOutputEnable_n = s_r.oe_n;
  assign sharedWriteEnable_n = s_r.we_n;
endmodule : emx_ctrl

// file: design/emx_pkg.sv
package emx_pkg;
  // bus widths
  localparam int ADDR_W = 20;
  localparam int DATA_W = 64;
  localparam int BE_W = 8;
  localparam int NSPACE = 4;
  localparam int APB_AW = 8;

  // primary space control offsets (byte addresses)
  localparam logic [7:0] OFS_CTL1 = 8'h04;
  localparam logic [7:0] OFS_CTL0 = 8'h08;
  localparam logic [7:0] OFS_CTL2 = 8'h10;
  localparam logic [7:0] OFS_CTL3 = 8'h14;
  // secondary space control offsets
  localparam logic [7:0] OFS_SEC1 = 8'h44;
  localparam logic [7:0] OFS_SEC0 = 8'h48;
  localparam logic [7:0] OFS_SEC2 = 8'h50;
  localparam logic [7:0] OFS_SEC3 = 8'h54;
  // access launch and result registers
  localparam logic [7:0] OFS_ADDR = 8'h60;
  localparam logic [7:0] OFS_WDLO = 8'h64;
  localparam logic [7:0] OFS_WDHI = 8'h68;
  localparam logic [7:0] OFS_CMD = 8'h6c;
  localparam logic [7:0] OFS_RDLO = 8'h70;
  localparam logic [7:0] OFS_RDHI = 8'h74;
  localparam logic [7:0] OFS_STAT = 8'h78;

  // primary space control fields
  localparam int WS_POS = 28;
  localparam int WST_POS = 22;
  localparam int WH_POS = 20;
  localparam int RS_POS = 16;
  localparam int RST_POS = 8;
  localparam int SYNC_POS = 4;
  localparam int RH_POS = 0;
  localparam int SETUP_W = 4;
  localparam int STROBE_W = 6;
  localparam int HOLD_W = 2;

  // secondary control fields
  localparam int SRL_POS = 0;
  localparam int SWL_POS = 2;
  localparam int CHIP_ENABLE_EXTEND_POS = 4;
  localparam int RENSEL_POS = 5;
  localparam int SYNC_CLOCK_SELECT_POS = 6;
  localparam int SEC_W = 7;

  // launch address register fields
  localparam int AR_SPACE_POS = 20;
  localparam int AR_BE_POS = 24;
  // command and status bits
  localparam int CMD_GO_POS = 0;
  localparam int CMD_WR_POS = 1;
  localparam int ST_BUSY_POS = 0;
  localparam int ST_DONE_POS = 1;

  // reset values
  localparam logic [31:0] CTL_RST = 32'hffff3f03;
  localparam logic [SEC_W-1:0] SEC_RST = 7'h00;

  // ready window: cycles before programmed strobe end
  localparam logic [5:0] RDY_WINDOW = 6'h02;
  // default half period of divided clock in clk cycles
  localparam int DIV_HALF = 2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ASETUP = 3'b001,
    ST_ASTROBE = 3'b010,
    ST_AHOLD = 3'b011,
    ST_SCMD = 3'b100,
    ST_SLAT = 3'b101,
    ST_SDESEL = 3'b110
  } emx_state_t;
endpackage : emx_pkg

// file: tb/emx_ctrl_props.sv
`timescale 1ns/1ps
module emx_ctrl_props #(
  parameter int DIV_HALF = 2
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic memClockOutDivided,
  input wire logic [emx_pkg::NSPACE-1:0] spaceChipEnable_n,
  input wire logic [emx_pkg::BE_W-1:0] byteLaneEnable_n,
  input wire logic [emx_pkg::ADDR_W-1:0] extAddressBus,
  input wire logic [emx_pkg::DATA_W-1:0] extDataBusOut,
  input wire logic extDataBusOe_n,
  input wire logic sharedStrobe_n,
  input wire logic sharedOutputEnable_n,
  input wire logic sharedWriteEnable_n,
  input wire logic extReadyIn
);
  import emx_pkg::*;
  int divCnt;
  logic divSeen;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // cycles since the divided clock last moved
  always_ff @(posedge clk) begin
    if (reset) begin
      divCnt <= 0;
      divSeen <= 1'b0;
    end else if ($changed(memClockOutDivided)) begin
      divCnt <= 0;
      divSeen <= 1'b1;
    end else begin
      divCnt <= divCnt + 1;
    end
  end
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  pready_cause_a: assert property (pready |-> $past(psel) && !$past(penable))
    else $error("pready without setup cycle");
  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  div_period_a: assert property ($changed(memClockOutDivided) && divSeen |->
    divCnt == DIV_HALF - 1) else $error("divided clock half period wrong");
  ce_onehot_a: assert property ($countones(~spaceChipEnable_n) <= 1)
    else $error("two chip enables low");
  oe_we_excl_a: assert property (!(!sharedOutputEnable_n && !sharedWriteEnable_n))
    else $error("output and write enable both low");
  oe_drive_excl_a: assert property (!sharedOutputEnable_n |-> extDataBusOe_n)
    else $error("data driven while memory output enabled");
  rd_sel_stable_a: assert property (!sharedStrobe_n && !$past(sharedStrobe_n) && !sharedOutputEnable_n |->
    $stable(extAddressBus) && $stable(spaceChipEnable_n)) else $error("select moved in strobe");
  wr_sel_stable_a: assert property (!sharedWriteEnable_n && !$past(sharedWriteEnable_n) |->
    $stable(extDataBusOut) && $stable(byteLaneEnable_n)) else $error("write select moved");
  ready_end_a: assert property ($rose(sharedStrobe_n) |-> $past(extReadyIn, 2))
    else $error("strobe ended while ready low");
  cov_rd_c: cover property ($fell(sharedStrobe_n) && !sharedOutputEnable_n);
  cov_stall_c: cover property (!sharedWriteEnable_n && !extReadyIn);
  cov_err_c: cover property (pslverr);
endmodule : emx_ctrl_props

bind emx_ctrl emx_ctrl_props #(.DIV_HALF(DIV_HALF)) props_i (.*);

// file: tb/emx_mem_model.sv
`timescale 1ns/1ps
module emx_mem_model #(
  parameter logic [63:0] WORD = 64'h5a3c96e10f87d24b
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] ceN,
  input wire logic strobeN,
  input wire logic oeN,
  input wire logic weN,
  input wire logic memClk,
  input wire logic useDiv,
  input wire logic syncMode,
  input wire logic [1:0] lat,
  input wire logic [3:0] stall,
  output logic [63:0] dataOut,
  output logic ready
);
  logic [4:0] pipe;
  logic clkPrev;
  logic stbPrev;
  logic flip = 1'b0;
  logic cmdNow;
  logic valid;
  int stallCnt;
  assign cmdNow = (ceN != 4'hf) && !strobeN && !oeN;
  assign valid = syncMode ? (lat == 2'd0 ? cmdNow : pipe[lat - 2'd1]) : cmdNow || !oeN;
  // released bus shows a pattern that moves every cycle
  assign dataOut = valid ? WORD : {64{flip}} ^ ~WORD;
  assign ready = (stallCnt == 0);
  // read pipe per step, ready stall per strobe or write enable fall
  always @(posedge clk) begin
    clkPrev <= memClk;
    flip <= !flip;
    stbPrev <= strobeN && weN;
    // steps on selected clock: edge where the divided clock rises
    // (low on two samples in a row, for a half period of two cycles)
    if (reset) begin
      pipe <= 5'h00;
    end else if (!useDiv || (!memClk && !clkPrev)) begin
      pipe <= {pipe[3:0], cmdNow};
    end
    // ready held low for stall cycles once strobe or write enable falls
    if (reset) begin
      stallCnt <= 0;
    end else if (!syncMode && stbPrev && !(strobeN && weN) && stall != 4'h0) begin
      stallCnt <= stall;
    end else if (stallCnt != 0) begin
      stallCnt <= stallCnt - 1;
    end
  end
endmodule : emx_mem_model

// file: tb/ext_mem_async_sync_cycles_tb_top.sv
`timescale 1ns/1ps
module ext_mem_async_sync_cycles_tb_top;
  import emx_pkg::*;
  localparam logic [63:0] WORD = 64'h5a3c96e10f87d24b;
  logic clk, reset, psel, penable, pwrite, pready, pslverr, memDiv, oeD, stbN, oeN, weN;
  logic ready, useDiv, syncMode;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] ceN, stall;
  logic [7:0] beN;
  logic [19:0] addr;
  logic [1:0] lat;
  logic [63:0] dIn, dOut, wrSeen;
  logic e;
  int fails, checked, cyc, nStb, nWe, nCe, nOe, weAt, drvAt;
  emx_ctrl #(.DIV_HALF(2)) dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .memClockOutDivided(memDiv), .spaceChipEnable_n(ceN),
    .byteLaneEnable_n(beN), .extAddressBus(addr), .extDataBusIn(dIn), .extDataBusOut(dOut),
    .extDataBusOe_n(oeD), .sharedStrobe_n(stbN), .sharedOutputEnable_n(oeN),
    .sharedWriteEnable_n(weN), .extReadyIn(ready));
  emx_mem_model #(.WORD(WORD)) mem (.clk(clk), .reset(reset), .ceN(ceN), .strobeN(stbN),
    .oeN(oeN), .weN(weN), .memClk(memDiv), .useDiv(useDiv), .syncMode(syncMode), .lat(lat),
    .stall(stall), .dataOut(dIn), .ready(ready));
  // clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = !clk;
  end
  // pin activity counters
  always @(posedge clk) begin
    cyc <= cyc + 1;
    nStb <= nStb + int'(!stbN);
    nWe <= nWe + int'(!weN);
    nCe <= nCe + int'(ceN != 4'hf);
    nOe <= nOe + int'(!oeN);
    if ($fell(weN)) weAt <= cyc;
    if ($fell(oeD)) drvAt <= cyc;
    if (!oeD) wrSeen <= dOut;
  end
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20) fails++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic access(input logic [1:0] sp, input logic wr);
    int n;
    n = 0;
    apb(1'b1, OFS_ADDR, {8'hff, 2'b00, sp, 20'h2b5c1});
    apb(1'b1, OFS_CMD, {30'h0, wr, 1'b1});
    q = 32'h0;
    while (q[ST_DONE_POS] !== 1'b1 && n < 200) begin
      apb(1'b0, OFS_STAT, 32'h0);
      n++;
    end
    if (n >= 200) fails++;
    apb(1'b1, OFS_STAT, 32'h2);
  endtask : access
  function automatic logic [31:0] ctl(int ws, int write_strobe_cycles, int wh, int rs, int rst, int rh, int sy);
    return (ws << WS_POS) | (write_strobe_cycles << WST_POS) | (wh << WH_POS) | (rs << RS_POS)
      | (rst << RST_POS) | (sy << SYNC_POS) | (rh << RH_POS);
  endfunction : ctl
  task automatic t_regs;
    apb(1'b0, OFS_CTL0, 32'h0);
    chk("ctl0 reset", q, CTL_RST);
    apb(1'b1, OFS_SEC2, 32'h55);
    apb(1'b0, OFS_SEC2, 32'h0);
    chk("sec2", q, 32'h55);
    apb(1'b0, OFS_SEC3, 32'h0);
    chk("sec3 reset", q, 32'h0);
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped err", e, 1'b1);
    $display("test regs done");
  endtask : t_regs
  task automatic t_async;
    int s, c;
    s = nStb;
    c = nCe;
    apb(1'b1, OFS_CTL0, ctl(2, 3, 2, 1, 2, 1, 0));
    access(2'd0, 1'b0);
    chk("rd strobe", nStb - s, 2);
    chk("rd selects", nCe - c, 5);
    apb(1'b0, OFS_RDLO, 32'h0);
    chk("rd lo", q, WORD[31:0]);
    apb(1'b0, OFS_RDHI, 32'h0);
    chk("rd hi", q, WORD[63:32]);
    apb(1'b1, OFS_WDLO, 32'h13579bdf);
    apb(1'b1, OFS_WDHI, 32'h2468ace0);
    s = nWe;
    c = nCe;
    access(2'd0, 1'b1);
    chk("wr strobe", nWe - s, 3);
    chk("wr selects", nCe - c, 8);
    chk("wr data", wrSeen, 64'h2468ace013579bdf);
    // long strobe so the synchronised ready lands in the window
    apb(1'b1, OFS_CTL0, ctl(2, 8, 2, 1, 2, 1, 0));
    stall <= 4'd6;
    s = nWe;
    access(2'd0, 1'b1);
    stall <= 4'd0;
    chk("wr stretched", (nWe - s) > 8, 1'b1);
    $display("test async done");
  endtask : t_async
  task automatic t_sync;
    int s, c, o, sc;
    for (int i = 0; i < 4; i++) begin
      sc = (i == 3) ? 4 : 1;
      lat <= 2'(i);
      useDiv <= (i == 3);
      syncMode <= 1'b1;
      apb(1'b1, OFS_CTL1, ctl(1, 1, 1, 1, 1, 1, 1));
      apb(1'b1, OFS_SEC1, {25'h0, i == 3, i[1], i[0], 2'(i), 2'(i)});
      s = nStb;
      c = nCe;
      o = nOe;
      access(2'd1, 1'b0);
      apb(1'b0, OFS_RDLO, 32'h0);
      chk("sync rd", q, WORD[31:0]);
      chk("sync stb", nStb - s, (i[1] ? 1 : 2) * sc);
      if (i[0]) chk("ce ext", nCe - c, nOe - o);
      else chk("ce drop", nCe - c, sc);
      access(2'd1, 1'b1);
      chk("wr lat", drvAt - weAt, i * sc);
    end
    syncMode <= 1'b0;
    useDiv <= 1'b0;
    $display("test sync done");
  endtask : t_sync
  task automatic finish_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  // watchdog
  initial begin
    #(25 * 30000);
    fails++;
    finish_test();
  end
  // main sequence
  initial begin
    {reset, psel, penable, pwrite, useDiv, syncMode} = 6'b100000;
    {paddr, pwdata, lat, stall, cyc, nStb, nWe, nCe, nOe, weAt, drvAt} = '0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_regs();
    t_async();
    t_sync();
    finish_test();
  end
endmodule : ext_mem_async_sync_cycles_tb_top
